// >>> hw/rpsr_dev.sv
/*
 * rpsr_dev: per-channel receive back end; phase synchronizer FIFO, bit-slip
 * realigner and an output word buffer, plus the generic FIFO they use.
 * Assumes parallel words arrive with a write strobe at the low-speed rate and
 * that the far end obeys the request pulse widths.
 */
`timescale 1ns/1ps

// =====================================================
// generic FIFO, valid and ready on both sides
module rpsr_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// fill side
	input  wire logic [W-1:0] i_data,
	input  wire logic         i_valid,
	output      logic         o_ready,
	// drain side
	output      logic [W-1:0] o_data,
	output      logic         o_valid,
	input  wire logic         i_ready
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
	localparam logic [AW-1:0] LAST  = (AW)'(D-1);

	logic [W-1:0]  mem [D];     // storage entries
	logic [AW-1:0] wr_ptr_reg;  // next entry to write
	logic [AW-1:0] rd_ptr_reg;  // next entry to read
	logic [AW:0]   count_reg;   // entries held
	logic          push;        // write this cycle
	logic          pop;         // read this cycle

	assign o_ready = (count_reg != FULL_CNT);
	assign o_valid = (count_reg != '0);
	assign o_data  = mem[rd_ptr_reg];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// storage write, no reset needed on data
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= i_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push & !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : rpsr_fifo

// =====================================================
// Overview of operation
// - each channel owns a four-entry synchronizer FIFO
// - written on parallel, read on global rate
// - equal rates, so FIFO fills only on a stalled fabric
// - realign parallel words per channel, global rate
// - request comes from pin or fabric logic
// - each request rising edge slips one bit
// - realigner always in path, latency only
// - deserialization factor of 8 or 10
// - word picked from two stages by counter
// - new valid word next low-speed cycle
// - request stays high two low-speed periods
// - request low three base periods between
// - checker requests again on a mismatch while in HUNT
// - checker registers input words first
// - checker registers request before driving it
// - sampling rate matches serial data rate
module rpsr_dev #(
	parameter int J = rpsr_pkg::DESER_J
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// deserialized words from the parallel side
	input  wire logic [J-1:0] i_par_data,
	input  wire logic         i_par_valid,
	output      logic         o_par_ready,
	// request pin and its source select
	input  wire logic         i_align_pin,
	input  wire logic         i_align_pin_sel,
	// status
	output      logic [rpsr_pkg::CNT_W-1:0] o_slip_count,
	// link toward the fabric
	rpsr_link_if.dev          link
);
	localparam logic [rpsr_pkg::CNT_W-1:0] CNT_LAST = (rpsr_pkg::CNT_W)'(J-1);

	logic [rpsr_pkg::CNT_W-1:0] div_reg;     // base-to-low-speed divider
	logic                       ls_en;       // one pulse per word period
	logic [J-1:0]               sync_data;   // synchronizer head word
	logic                       sync_valid;  // synchronizer holds a word
	logic                       take;        // word moves into the realigner
	logic                       out_ready;   // output buffer has room
	logic [J-1:0]               stage2_reg;  // newest word
	logic [J-1:0]               stage3_reg;  // previous word
	logic [2*J-1:0]             window;      // two words side by side
	logic [J-1:0]               aligned;     // slipped word
	logic [J-1:0]               word_reg;    // registered aligned word
	logic                       word_vld_reg; // word_reg is new
	logic [rpsr_pkg::CNT_W-1:0] slip_reg;    // slip counter
	logic                       pin_s1_reg;  // pin synchronizer first stage
	logic                       pin_s2_reg;  // pin synchronizer second stage
	logic                       sel_s1_reg;  // select synchronizer first stage
	logic                       sel_s2_reg;  // select synchronizer second stage
	logic                       req_level;   // chosen request source
	logic                       req_prev_reg; // request at last ls_en
	logic                       req_rise;    // captured rising edge

	// =====================================================
	// rate divider
	// base clock runs at the serial bit rate; one enable per J bits
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_reg <= '0;
		end else if (div_reg == CNT_LAST) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end
	assign ls_en      = (div_reg == CNT_LAST);
	assign link.ls_en = ls_en;

	// =====================================================
	// phase synchronizer
	// fill side is the parallel strobe, drain side the global enable
	rpsr_fifo #(
		.W (J),
		.D (rpsr_pkg::SYNC_DEPTH)
	) u_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_data  (i_par_data),
		.i_valid (i_par_valid),
		.o_ready (o_par_ready),
		.o_data  (sync_data),
		.o_valid (sync_valid),
		.i_ready (ls_en & out_ready)
	);
	// at locked rates the flags never act; they only stall on a stalled fabric
	assign take = ls_en & sync_valid & out_ready;

	// =====================================================
	// request source and edge capture
	// pin passes two flops before use
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			sel_s1_reg <= 1'b0;
			sel_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg <= i_align_pin;
			pin_s2_reg <= pin_s1_reg;
			sel_s1_reg <= i_align_pin_sel;
			sel_s2_reg <= sel_s1_reg;
		end
	end
	assign req_level = sel_s2_reg ? pin_s2_reg : link.align_req;

	// sample at the low-speed rate; a two-period high is always seen
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			req_prev_reg <= 1'b0;
		end else if (ls_en) begin
			req_prev_reg <= req_level;
		end
	end
	assign req_rise = ls_en & req_level & ~req_prev_reg;

	// =====================================================
	// slip counter
	// one step per captured edge, wraps after J-1
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			slip_reg <= '0;
		end else if (req_rise) begin
			if (slip_reg == CNT_LAST) begin
				slip_reg <= '0;
			end else begin
				slip_reg <= slip_reg + 1'b1;
			end
		end
	end
	assign o_slip_count = slip_reg;

	// =====================================================
	// realignment stages
	// shift only when a word is taken
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else if (take) begin
			stage2_reg <= sync_data;
			stage3_reg <= stage2_reg;
		end
	end

	// bit 0 is the earliest bit; count 0 takes stage 3 whole
	assign window  = {stage2_reg, stage3_reg};
	assign aligned = window[slip_reg +: J];

	// output register, present in every mode
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			word_reg     <= '0;
			word_vld_reg <= 1'b0;
		end else begin
			word_vld_reg <= take;
			if (take) begin
				word_reg <= aligned;
			end
		end
	end

	// =====================================================
	// word buffer toward the fabric
	// a stalled fabric fills it, then the synchronizer, then the source
	rpsr_fifo #(
		.W (J),
		.D (rpsr_pkg::OUT_DEPTH)
	) u_out (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_data  (word_reg),
		.i_valid (word_vld_reg),
		.o_ready (out_ready),
		.o_data  (link.word),
		.o_valid (link.word_valid),
		.i_ready (link.word_ready)
	);
endmodule : rpsr_dev

// >>> hw/rpsr_host.sv
/*
 * rpsr_host: fabric pattern checker; compares realigned words with a known
 * pattern and pulses the realignment request until they match.
 * Assumes the link ls_en pulse marks the low-speed rate.
 */
`timescale 1ns/1ps
module rpsr_host #(
	parameter int J = rpsr_pkg::DESER_J
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// user side
	input  wire logic [J-1:0] i_pattern,
	input  wire logic         i_hold,
	output      logic [J-1:0] o_word,
	output      logic         o_word_valid,
	output      logic         o_locked,
	// link toward the realigner
	rpsr_link_if.host         link
);
	localparam logic [3:0] HIGH_LAST  = 4'(rpsr_pkg::REQ_HIGH_LS - 1);
	localparam logic [3:0] GUARD_LAST = 4'(rpsr_pkg::GUARD_LS - 1);
	localparam logic [3:0] LOCK_LAST  = 4'(rpsr_pkg::LOCK_MATCHES - 1);

	rpsr_pkg::rpsr_state_t state_reg;   // checker state
	logic [3:0]  tmr_reg;               // low-speed periods in state
	logic [3:0]  match_reg;             // matches in a row
	logic [J-1:0] in_reg;               // input register
	logic        in_vld_reg;            // in_reg is new
	logic        req_reg;               // registered request
	logic        accept;                // word taken this cycle
	logic        mismatch;              // registered word differs

	assign link.word_ready = ~i_hold;
	assign accept          = link.word_valid & ~i_hold;
	assign mismatch        = in_vld_reg & (in_reg != i_pattern);
	assign o_word          = in_reg;
	assign o_word_valid    = in_vld_reg;
	assign o_locked        = (state_reg == rpsr_pkg::RPSR_LOCK);
	assign link.align_req  = req_reg;

	// =====================================================
	// input register
	// every word is registered before it is compared
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			in_reg     <= '0;
			in_vld_reg <= 1'b0;
		end else begin
			in_vld_reg <= accept;
			if (accept) begin
				in_reg <= link.word;
			end
		end
	end

	// =====================================================
	// checker state machine
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= rpsr_pkg::RPSR_HUNT;
			tmr_reg   <= '0;
			match_reg <= '0;
		end else begin
			unique case (state_reg)
				// compare, slip on the first mismatch
				rpsr_pkg::RPSR_HUNT: begin
					if (mismatch) begin
						state_reg <= rpsr_pkg::RPSR_PULSE;
						tmr_reg   <= '0;
						match_reg <= '0;
					end else if (in_vld_reg) begin
						if (match_reg == LOCK_LAST) begin
							state_reg <= rpsr_pkg::RPSR_LOCK;
						end else begin
							match_reg <= match_reg + 1'b1;
						end
					end
				end
				// request high for two low-speed periods
				rpsr_pkg::RPSR_PULSE: begin
					if (link.ls_en) begin
						if (tmr_reg == HIGH_LAST) begin
							state_reg <= rpsr_pkg::RPSR_GUARD;
							tmr_reg   <= '0;
						end else begin
							tmr_reg <= tmr_reg + 1'b1;
						end
					end
				end
				// request low well beyond three base periods
				rpsr_pkg::RPSR_GUARD: begin
					if (link.ls_en) begin
						if (tmr_reg == GUARD_LAST) begin
							state_reg <= rpsr_pkg::RPSR_HUNT;
							tmr_reg   <= '0;
						end else begin
							tmr_reg <= tmr_reg + 1'b1;
						end
					end
				end
				// locked; a mismatch restarts the hunt
				rpsr_pkg::RPSR_LOCK: begin
					if (mismatch) begin
						state_reg <= rpsr_pkg::RPSR_HUNT;
						match_reg <= '0;
					end
				end
			endcase
		end
	end

	// =====================================================
	// request register on the low-speed rate
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			req_reg <= 1'b0;
		end else if (link.ls_en) begin
			req_reg <= (state_reg == rpsr_pkg::RPSR_PULSE);
		end
	end
endmodule : rpsr_host

// >>> hw/rpsr_link_if.sv
/*
 * rpsr_link_if: link between the realigner end and the pattern checker end.
 * Assumes both ends run on the same base clock and reset.
 */
`timescale 1ns/1ps
interface rpsr_link_if #(
	parameter int J = rpsr_pkg::DESER_J
) ();
	logic [J-1:0] word;        // realigned word toward the fabric
	logic         word_valid;  // word is present
	logic         word_ready;  // fabric takes the word
	logic         ls_en;       // low-speed enable pulse, one per word period
	logic         align_req;   // realignment request from fabric logic

	// =====================================================
	// realigner end
	modport dev (
		output word,
		output word_valid,
		input  word_ready,
		output ls_en,
		input  align_req
	);
	// =====================================================
	// pattern checker end
	modport host (
		input  word,
		input  word_valid,
		output word_ready,
		input  ls_en,
		output align_req
	);
endinterface : rpsr_link_if

// >>> hw/rpsr_pkg.sv
/*
 * rpsr_pkg: shared constants of the receive phase synchronizer and bit realigner.
 * Assumes one base-rate clock; slower rates are enable pulses derived from it.
 */
package rpsr_pkg;
	// =====================================================
	// word format
	localparam int DESER_J      = 10;   // deserialization factor, 8 or 10
	localparam int CNT_W        = 4;    // slip counter width, holds 0..9
	// =====================================================
	// buffering
	localparam int SYNC_DEPTH   = 4;    // phase synchronizer entries
	localparam int OUT_DEPTH    = 8;    // word buffer toward the fabric
	// =====================================================
	// clocking
	localparam int CLK_MHZ      = 40;   // base clock rate
	localparam int CLK_PERIOD_NS = 25;  // base clock period
	// =====================================================
	// pattern checker timing, in low-speed periods except REQ_LOW_BASE
	localparam int REQ_HIGH_LS  = 2;    // request high time
	localparam int REQ_LOW_BASE = 3;    // least low time, base periods
	localparam int GUARD_LS     = 8;    // low time, covers pipeline refill
	localparam int LOCK_MATCHES = 4;    // matches in a row to declare lock
	// =====================================================
	// checker states, gray except the GUARD to HUNT step
	typedef enum logic [1:0] {
		RPSR_HUNT  = 2'h0,               // comparing words
		RPSR_PULSE = 2'h1,               // request high
		RPSR_GUARD = 2'h3,               // request low, waiting for refill
		RPSR_LOCK  = 2'h2                // pattern found
	} rpsr_state_t;
endpackage : rpsr_pkg

// >>> tb/rpsr_link_sva.sv
/*
 * rpsr_link_sva: timing checks on the link between realigner and checker.
 * Assumes one clock, async active-low reset, signals taken from the link.
 */
`timescale 1ns/1ps
module rpsr_link_sva #(
	parameter int J = 10
) (
	// clock and reset
	input wire logic         i_clk,
	input wire logic         i_nrst,
	// link signals
	input wire logic [J-1:0] word,
	input wire logic         word_valid,
	input wire logic         word_ready,
	input wire logic         ls_en,
	input wire logic         align_req
);
	// =====================================================
	// helper counters
	localparam int HIGH_MIN = rpsr_pkg::REQ_HIGH_LS * J; // least high cycles
	localparam int LOW_MIN  = rpsr_pkg::GUARD_LS * J;    // least low cycles
	logic [7:0] hi_reg;   // request-high cycles in a row
	logic [7:0] lo_reg;   // request-low cycles in a row, saturating
	logic [7:0] gap_reg;  // cycles since last ls_en
	logic       seen_reg; // an ls_en seen since reset

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	// request width counters
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hi_reg <= 8'h00;
			lo_reg <= 8'hFF;
		end else if (align_req) begin
			hi_reg <= (hi_reg == 8'hFF) ? hi_reg : hi_reg + 8'h01;
			lo_reg <= 8'h00;
		end else begin
			hi_reg <= 8'h00;
			lo_reg <= (lo_reg == 8'hFF) ? lo_reg : lo_reg + 8'h01;
		end
	end

	// low-speed period counter
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_reg  <= 8'h00;
			seen_reg <= 1'b0;
		end else begin
			gap_reg  <= ls_en ? 8'h01 : gap_reg + 8'h01;
			seen_reg <= seen_reg | ls_en;
		end
	end

	// =====================================================
	// assertions
	a_ls_en_period: assert property (ls_en && seen_reg |-> gap_reg == 8'(J))
		else $error("ls_en spacing differs from word length");
	a_ls_en_pulse: assert property (ls_en |=> !ls_en)
		else $error("ls_en longer than one cycle");
	a_valid_hold: assert property (word_valid && !word_ready |=> word_valid)
		else $error("word withdrawn before taken");
	a_word_stable: assert property (word_valid && !word_ready |=> $stable(word))
		else $error("word changed before taken");
	a_req_on_ls: assert property ($changed(align_req) |-> $past(ls_en))
		else $error("request changed off the low-speed edge");
	a_req_high_len: assert property ($fell(align_req) |-> hi_reg >= 8'(HIGH_MIN))
		else $error("request high too short");
	a_req_low_min: assert property ($fell(align_req) |-> !align_req [*3])
		else $error("request low under three cycles");
	a_req_gap_guard: assert property ($rose(align_req) |-> lo_reg >= 8'(LOW_MIN))
		else $error("request repeated before refill");

	// main scenarios
	c_req_rise: cover property ($rose(align_req));
	c_stall: cover property (word_valid && !word_ready);
	c_two_req: cover property ($fell(align_req) ##[1:300] $rose(align_req));
endmodule : rpsr_link_sva

// >>> tb/rx_phase_sync_bit_realigner_tb.sv
/*
 * rx_phase_sync_bit_realigner_tb: both ends joined by the link, fed with a
 * rotated training word; checks slips, lock, wrap, pin source and stall.
 * Assumes design ends as declared in hw/, one 40 MHz clock.
 */
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module rx_phase_sync_bit_realigner_tb;
	// =====================================================
	// settings and signals
	localparam int           J     = rpsr_pkg::DESER_J;
	localparam logic [J-1:0] PAT   = 10'h1A7; // aperiodic training word
	localparam int           LIMIT = 30000;   // cycle ceiling
	typedef struct { int off; logic [rpsr_pkg::CNT_W-1:0] slip; } rpsr_row_t;
	rpsr_row_t                  rows [4];         // offset beside lock slip
	logic                       i_clk      = 1'b0;
	logic                       i_nrst     = 1'b0;
	logic [J-1:0]               par_data   = '0;
	logic                       par_valid  = 1'b0;
	logic                       align_pin  = 1'b0;
	logic                       pin_sel    = 1'b0;
	logic                       hold       = 1'b0;
	logic                       par_ready;
	logic [rpsr_pkg::CNT_W-1:0] slip_count;
	logic [J-1:0]               word;
	logic                       word_valid;
	logic                       locked;
	int                         off = 0;      // stream bit offset
	int                         feed_cnt = 0; // word period counter
	int                         cycles = 0;
	int                         n_fail = 0;
	int                         compares = 0;

	always #12.5 i_clk = ~i_clk;

	// =====================================================
	// ends and checker
	rpsr_link_if #(.J(J)) lnk ();
	rpsr_dev #(.J(J)) u_rpsr_dev (.i_clk(i_clk), .i_nrst(i_nrst), .i_par_data(par_data),
		.i_par_valid(par_valid), .o_par_ready(par_ready), .i_align_pin(align_pin),
		.i_align_pin_sel(pin_sel), .o_slip_count(slip_count), .link(lnk));
	rpsr_host #(.J(J)) u_rpsr_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_pattern(PAT), .i_hold(hold),
		.o_word(word), .o_word_valid(word_valid), .o_locked(locked), .link(lnk));
	rpsr_link_sva #(.J(J)) chk_link (.i_clk(i_clk), .i_nrst(i_nrst), .word(lnk.word),
		.word_valid(lnk.word_valid), .word_ready(lnk.word_ready), .ls_en(lnk.ls_en),
		.align_req(lnk.align_req));

	// word whose bit i is stream bit off+i of the repeated pattern
	function automatic logic [J-1:0] rot(input int sh);
		logic [J-1:0] r;
		for (int i = 0; i < J; i++) begin
			r[i] = PAT[(i + sh) % J];
		end
		return r;
	endfunction : rot

	// offer one word per word period, bit 0 earliest
	always @(negedge i_clk) begin
		feed_cnt  <= (feed_cnt == J - 1) ? 0 : feed_cnt + 1;
		par_valid <= (feed_cnt == 0);
		par_data  <= rot(off);
	end

	// hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_fail++;
			end_of_test();
		end
	end

	// =====================================================
	// tasks
	task automatic do_reset();
		i_nrst = 1'b0;
		repeat (16) @(negedge i_clk);
		i_nrst = 1'b1;
	endtask : do_reset

	task automatic wait_lock();
		int n;
		n = 0;
		while (locked !== 1'b1 && n < 4000) begin
			@(negedge i_clk);
			n++;
		end
	endtask : wait_lock

	// wait for a delivered word, then compare it
	task automatic check_word();
		int n;
		n = 0;
		while (word_valid !== 1'b1 && n < 8 * J) begin
			@(negedge i_clk);
			n++;
		end
		`CHECK_EQ(word, PAT)
		@(negedge i_clk);
	endtask : check_word

	task automatic end_of_test();
		$display("counts: compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	// =====================================================
	// main sequence
	initial begin
		rows = '{'{0, 4'h0}, '{3, 4'h7}, '{7, 4'h3}, '{1, 4'h9}};
		repeat (15) @(negedge i_clk);
		`CHECK_EQ(par_ready, 1'b1)
		`CHECK_EQ(lnk.word_valid, 1'b0)
		`CHECK_EQ(lnk.ls_en, 1'b0)
		`CHECK_EQ(slip_count, 4'h0)
		`CHECK_EQ(lnk.align_req, 1'b0)
		`CHECK_EQ(locked, 1'b0)
		$display("reset test done");
		// each offset must settle on its own slip count
		foreach (rows[r]) begin
			off = rows[r].off;
			if (r > 0) begin
				do_reset();
			end else begin
				// start-up reset already low for 15 cycles; release on the 16th
				@(negedge i_clk);
				i_nrst = 1'b1;
			end
			wait_lock();
			`CHECK_EQ(locked, 1'b1)
			`CHECK_EQ(slip_count, rows[r].slip)
			check_word();
			$display("row test %0d done", r);
		end
		// pin source: long high slips once, wraps J-1 to 0
		pin_sel = 1'b1;
		repeat (4) @(negedge i_clk);
		align_pin = 1'b1;
		repeat (5 * J) @(negedge i_clk);
		align_pin = 1'b0;
		repeat (3 * J) @(negedge i_clk);
		`CHECK_EQ(slip_count, 4'h0)
		repeat (30 * J) @(negedge i_clk);
		`CHECK_EQ(slip_count, 4'h0)
		`CHECK_EQ(locked, 1'b0)
		pin_sel = 1'b0;
		wait_lock();
		`CHECK_EQ(slip_count, 4'h9)
		$display("wrap and pin test done");
		// stall until intake refuses, then drain
		hold = 1'b1;
		repeat (40 * J) @(negedge i_clk);
		`CHECK_EQ(par_ready, 1'b0)
		`CHECK_EQ(lnk.word_valid, 1'b1)
		hold = 1'b0;
		repeat (20 * J) @(negedge i_clk);
		check_word();
		`CHECK_EQ(locked, 1'b1)
		`CHECK_EQ(slip_count, 4'h9)
		$display("stall test done");
		end_of_test();
	end
endmodule : rx_phase_sync_bit_realigner_tb
